// >>> rtl/dio_defines.svh
// Constants of the digital I/O conditioning block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the rtl folder.
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

// ----
// Timing
// ----
`define DIO_CLK_NS 25
`define DIO_SAMPLE_NS 1000000
`define DIO_SAMPLE_CYC (`DIO_SAMPLE_NS / `DIO_CLK_NS)
`define DIO_LED_HALF_TICKS 16'h00FA

// ----
// Register byte offsets
// ----
`define DIO_OFS_IN_SFE 8'h00
`define DIO_OFS_IN_INV 8'h04
`define DIO_OFS_IN_FEN 8'h08
`define DIO_OFS_IN_FVAL 8'h0C
`define DIO_OFS_IN_RAW 8'h10
`define DIO_OFS_IN_RTEN 8'h14
`define DIO_OFS_IN_STAT 8'h18
`define DIO_OFS_OUT_CMD 8'h1C
`define DIO_OFS_OUT_POL 8'h20
`define DIO_OFS_OUT_MEN 8'h24
`define DIO_OFS_OUT_MVAL 8'h28
`define DIO_OFS_OUT_APPL 8'h2C
`define DIO_OFS_OUT_RTEN 8'h30
`define DIO_OFS_LED 8'h34
`define DIO_OFS_FLT_REACT 8'h38
`define DIO_OFS_FLT_STAT 8'h3C
`define DIO_OFS_PIN_DIR 8'h40
`define DIO_OFS_ROUTE_BASE 8'h80

// ----
// Fields
// ----
`define DIO_STAT_ILOCK_BIT 3
`define DIO_SFE_ILOCK_BIT 3
`define DIO_OUT_BRAKE_BIT 0
`define DIO_OUT_PIN_BASE 16
`define DIO_LED_GREEN_BIT 0
`define DIO_LED_RED_BIT 1
`define DIO_FLT_ACTIVE_BIT 0
`define DIO_FLT_PERMIT_BIT 1
`define DIO_CODE_INV_BIT 7
`define DIO_SRC_ZERO 7'h00
`define DIO_SRC_PHYS_LAST 7'h10
`define DIO_SRC_HALL_U 7'h41
`define DIO_SRC_HALL_V 7'h42
`define DIO_SRC_HALL_W 7'h43
`define DIO_SRC_ENC_A 7'h44
`define DIO_SRC_ENC_B 7'h45
`define DIO_SRC_ENC_I 7'h46

// ----
// Reset values
// ----
`define DIO_RST_WORD 32'h0000_0000
`define DIO_RST_HALF 16'h0000
`define DIO_RST_CODE 8'h00

`endif

// >>> rtl/dio_pkg.sv
// Types shared by the digital I/O conditioning block.
// Assumes nothing of its surroundings.
package dio_pkg;

   typedef logic [7:0] dio_code_type;

   typedef enum logic [0:0] {
      DIO_FLT_IDLE,
      DIO_FLT_TRIP
   } dio_flt_type;

endpackage : dio_pkg

// >>> rtl/dio_in_sync.sv
// Input conditioner: two-flop synchroniser, sampling on a tick, two-sample agreement.
// Assumes a one-cycle tick once per sample period on the same clock.
`timescale 1ns/1ps
`default_nettype none

module dio_in_sync #(
   parameter int W = 6
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Sample tick and pins
   input wire logic tick,
   input wire logic [W-1:0] din,
   // Conditioned levels
   output logic [W-1:0] dout,
   output logic upd
);

   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] last_r;
   logic [W-1:0] keep_r;
   logic upd_r;
   wire logic [W-1:0] agree = ~(sync_r ^ last_r);
   wire logic [W-1:0] keep_nxt = (sync_r & agree) | (keep_r & ~agree);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
      end
   end

   // A level must be seen on two successive samples to pass
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         last_r <= '0;
         keep_r <= '0;
         upd_r <= 1'b0;
      end else begin
         upd_r <= tick;
         if (tick) begin
            last_r <= sync_r;
            keep_r <= keep_nxt; // [RL19]
         end
      end
   end

   assign dout = keep_r;
   assign upd = upd_r;

endmodule : dio_in_sync

`default_nettype wire

// >>> rtl/dio_route_mux.sv
// Source selector for one status bit of the routed input word.
// Assumes conditioned source levels on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "dio_defines.svh"

module dio_route_mux (
   // Selection
   input wire logic [7:0] code,
   // Sources
   input wire logic [15:0] phys,
   input wire logic [2:0] hall,
   input wire logic [2:0] enc,
   // Result
   output logic sel
);

   wire logic [6:0] src = code[6:0];
   wire logic inv = code[`DIO_CODE_INV_BIT];
   wire logic is_zero = (src == `DIO_SRC_ZERO);
   wire logic is_phys = (src != `DIO_SRC_ZERO) && (src <= `DIO_SRC_PHYS_LAST);
   wire logic is_hall = (src >= `DIO_SRC_HALL_U) && (src <= `DIO_SRC_HALL_W);
   wire logic is_enc = (src >= `DIO_SRC_ENC_A) && (src <= `DIO_SRC_ENC_I);
   wire logic [3:0] phys_idx = 4'(src - 7'h01);
   wire logic [1:0] hall_idx = 2'(src - `DIO_SRC_HALL_U);
   wire logic [1:0] enc_idx = 2'(src - `DIO_SRC_ENC_A);
   wire logic raw = is_phys ? phys[phys_idx] :
                    is_hall ? hall[hall_idx] :
                    is_enc ? enc[enc_idx] : 1'b0; // [RL5]
   wire logic known = is_zero | is_phys | is_hall | is_enc;

   // Undefined codes read zero whatever the inversion bit
   assign sel = known & (raw ^ inv); // [RL6] [RL20]

endmodule : dio_route_mux

`default_nettype wire

// >>> rtl/dio_top.sv
// Digital input routing and output conditioning of a motor controller, APB slave.
// Assumes a 40 MHz clk, asynchronous active-high sys_rst and raw pins on inputs.
//
// Function
// (RL1) In routing mode, input enable, polarity and force settings are ignored.
// (RL2) Enabling routing preloads route entries reproducing the previous input sources.
// (RL3) Software should not toggle repeatedly between normal and routing modes.
// (RL4) Route entry one selects status bit 0, entry two bit 1, upward.
// (RL5) Code 00 is zero, 01-10 physical inputs, 41-46 Hall and encoder lines.
// (RL6) Code bit 7 inverts the selected source; 80 gives constant one.
// (RL7) Interlock active: status bit 3 one permits motion, zero enters fault.
// (RL8) Interlock checked only while enable-mask bit 3 is set; source via routing.
// (RL9) Output n follows output word bit 15+n; low bits are special functions.
// (RL10) Only output word bit 0 is used, commanding the brake.
// (RL11) Only the first four shared pins drive outputs, gated by direction.
// (RL12) Per-output polarity bit: clear drives one high, set drives one low.
// (RL13) Manual-control mask bit selects manual value for that output, brake included.
// (RL14) Manual value gives the level applied to each manually controlled output.
// (RL15) A readable register holds the pattern actually applied to the outputs.
// (RL16) Output routing mode is enabled by writing one to its entry; the code only stores and reads back that bit, with no output routing.
// (RL17) LED bit 0 enables green flashing, bit 1 red on error; clear is off.
// (RL18) Input routing enable register written with one turns on routing.
// (RL19) Inputs sampled each millisecond; pulses shorter than a millisecond ignored.
// (RL20) Undefined source codes make their status bit read zero.
// (RL21) Route selections evaluated at each sample, reflected within one period.
`timescale 1ns/1ps
`default_nettype none
`include "dio_defines.svh"

module dio_top #(
   parameter int SAMPLE_CYCLES = `DIO_SAMPLE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Input pins
   input wire logic [5:0] dio_in,
   input wire logic [2:0] hall_in,
   input wire logic [2:0] enc_in,
   // Output pins
   output logic [3:0] dio_o,
   output logic [3:0] dio_oe,
   output logic brake_o,
   output logic brake_oe,
   // Status LEDs
   output logic led_green,
   output logic led_red,
   // Motion interlock
   output logic motion_permit,
   output logic fault_active,
   output logic [15:0] fault_reaction
);

   // ----
   // Sample tick
   // ----
   logic [15:0] tick_cnt_r;
   logic tick_r;
   wire logic tick_end = (tick_cnt_r == 16'(SAMPLE_CYCLES - 1));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_cnt_r <= 16'h0000;
         tick_r <= 1'b0;
      end else begin
         tick_cnt_r <= tick_end ? 16'h0000 : 16'(tick_cnt_r + 16'h0001);
         tick_r <= tick_end; // [RL19]
      end
   end

   // ----
   // Input conditioning
   // ----
   logic [11:0] src_f;
   logic src_upd;

   dio_in_sync #(.W(12)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick_r),
      .din({enc_in, hall_in, dio_in}),
      .dout(src_f),
      .upd(src_upd)
   );

   wire logic [15:0] phys_f = {10'h000, src_f[5:0]};
   wire logic [2:0] hall_f = src_f[8:6];
   wire logic [2:0] enc_f = src_f[11:9];

   // ----
   // APB access
   // ----
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   wire logic acc = psel & penable & ~pready_r;
   wire logic wr = psel & penable & pready_r & pwrite;
   wire logic is_route = paddr[7];
   wire logic [4:0] route_idx = paddr[6:2];
   wire logic hit = is_route || (paddr <= `DIO_OFS_PIN_DIR && paddr[1:0] == 2'b00);
   wire logic wr_reg = wr & ~is_route;

   // ----
   // Configuration registers
   // ----
   logic [15:0] in_sfe_r;
   logic [15:0] in_inv_r;
   logic [15:0] in_fen_r;
   logic [15:0] in_fval_r;
   logic in_rten_r;
   logic [31:0] out_cmd_r;
   logic [31:0] out_pol_r;
   logic [31:0] out_men_r;
   logic [31:0] out_mval_r;
   logic out_rten_r;
   logic [1:0] led_ctrl_r;
   logic [15:0] flt_react_r;
   logic [3:0] pin_dir_r;
   dio_pkg::dio_code_type route_r [0:31];

   wire logic rten_on = wr_reg && paddr == `DIO_OFS_IN_RTEN && pwdata[0] && !in_rten_r;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         in_sfe_r <= `DIO_RST_HALF;
         in_inv_r <= `DIO_RST_HALF;
         in_fen_r <= `DIO_RST_HALF;
         in_fval_r <= `DIO_RST_HALF;
         in_rten_r <= 1'b0;
         out_cmd_r <= `DIO_RST_WORD;
         out_pol_r <= `DIO_RST_WORD;
         out_men_r <= `DIO_RST_WORD;
         out_mval_r <= `DIO_RST_WORD;
         out_rten_r <= 1'b0;
         led_ctrl_r <= 2'b00;
         flt_react_r <= `DIO_RST_HALF;
         pin_dir_r <= 4'h0;
      end else if (wr_reg) begin
         case (paddr)
            `DIO_OFS_IN_SFE: in_sfe_r <= pwdata[15:0];
            `DIO_OFS_IN_INV: in_inv_r <= pwdata[15:0];
            `DIO_OFS_IN_FEN: in_fen_r <= pwdata[15:0];
            `DIO_OFS_IN_FVAL: in_fval_r <= pwdata[15:0];
            `DIO_OFS_IN_RTEN: in_rten_r <= pwdata[0]; // [RL18]
            `DIO_OFS_OUT_CMD: out_cmd_r <= pwdata;
            `DIO_OFS_OUT_POL: out_pol_r <= pwdata;
            `DIO_OFS_OUT_MEN: out_men_r <= pwdata;
            `DIO_OFS_OUT_MVAL: out_mval_r <= pwdata;
            `DIO_OFS_OUT_RTEN: out_rten_r <= pwdata[0]; // [RL16]
            `DIO_OFS_LED: led_ctrl_r <= pwdata[1:0];
            `DIO_OFS_FLT_REACT: flt_react_r <= pwdata[15:0];
            `DIO_OFS_PIN_DIR: pin_dir_r <= pwdata[3:0];
            default: pin_dir_r <= pin_dir_r;
         endcase
      end
   end

   // ----
   // Route table and routed word
   // ----
   wire logic [15:0] lvl = (in_fen_r & in_fval_r) | (~in_fen_r & (phys_f ^ in_inv_r));
   wire logic [31:0] norm_word = {lvl, in_sfe_r & lvl};
   logic [31:0] routed_word;

   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_route
         localparam int PI = g % 16;
         wire logic [7:0] self_code = {in_inv_r[PI], 7'(PI + 1)};
         wire logic [7:0] preload = (g >= 16 || in_sfe_r[PI]) ? self_code : `DIO_RST_CODE;

         // Entry g+1 (index g) drives status bit g
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               route_r[g] <= `DIO_RST_CODE;
            end else if (rten_on) begin
               route_r[g] <= preload; // [RL2]
            end else if (wr && is_route && route_idx == 5'(g)) begin
               route_r[g] <= pwdata[7:0]; // [RL4]
            end
         end

         dio_route_mux u_mux (
            .code(route_r[g]),
            .phys(phys_f),
            .hall(hall_f),
            .enc(enc_f),
            .sel(routed_word[g])
         );
      end
   endgenerate

   // ----
   // Input status word
   // ----
   logic [31:0] din_stat_r;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         din_stat_r <= `DIO_RST_WORD;
      end else if (src_upd) begin
         din_stat_r <= in_rten_r ? routed_word : norm_word; // [RL1] [RL21]
      end
   end

   // ----
   // Interlock
   // ----
   dio_pkg::dio_flt_type flt_r;
   logic permit_r;
   wire logic ilock_on = in_sfe_r[`DIO_SFE_ILOCK_BIT]; // [RL8]
   wire logic ilock_ok = din_stat_r[`DIO_STAT_ILOCK_BIT];
   wire logic flt_clr = wr_reg && paddr == `DIO_OFS_FLT_STAT && pwdata[`DIO_FLT_ACTIVE_BIT];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flt_r <= dio_pkg::DIO_FLT_IDLE;
      end else begin
         case (flt_r)
            dio_pkg::DIO_FLT_IDLE: if (ilock_on && !ilock_ok) flt_r <= dio_pkg::DIO_FLT_TRIP; // [RL7]
            dio_pkg::DIO_FLT_TRIP: if (flt_clr && !(ilock_on && !ilock_ok)) flt_r <= dio_pkg::DIO_FLT_IDLE;
            default: flt_r <= dio_pkg::DIO_FLT_IDLE;
         endcase
      end
   end

   wire logic trip = (flt_r == dio_pkg::DIO_FLT_TRIP);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         permit_r <= 1'b0;
      end else begin
         permit_r <= !trip && (!ilock_on || ilock_ok); // [RL7]
      end
   end

   // ----
   // Output processing
   // ----
   // Only the brake bit and the four pin bits take part
   wire logic [31:0] out_used = {12'h000, 4'hF, 15'h0000, 1'b1}; // [RL10] [RL11]
   wire logic [31:0] out_auto = out_cmd_r ^ out_pol_r; // [RL9] [RL12]
   wire logic [31:0] out_nxt = out_used & ((out_men_r & out_mval_r) | (~out_men_r & out_auto)); // [RL13] [RL14]
   logic [31:0] out_appl_r;
   logic [3:0] dio_o_r;
   logic [3:0] dio_oe_r;
   logic brake_oe_r;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_appl_r <= `DIO_RST_WORD;
         dio_o_r <= 4'h0;
         dio_oe_r <= 4'h0;
         brake_oe_r <= 1'b0;
      end else begin
         out_appl_r <= out_nxt; // [RL15]
         dio_o_r <= out_nxt[`DIO_OUT_PIN_BASE +: 4];
         dio_oe_r <= pin_dir_r; // [RL11]
         brake_oe_r <= ~out_nxt[`DIO_OUT_BRAKE_BIT];
      end
   end

   // ----
   // Status LEDs
   // ----
   logic [15:0] blink_cnt_r;
   logic blink_r;
   logic led_g_r;
   logic led_r_r;
   wire logic blink_end = (blink_cnt_r == 16'(`DIO_LED_HALF_TICKS - 16'h0001));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         blink_cnt_r <= 16'h0000;
         blink_r <= 1'b0;
         led_g_r <= 1'b0;
         led_r_r <= 1'b0;
      end else begin
         if (tick_r) begin
            blink_cnt_r <= blink_end ? 16'h0000 : 16'(blink_cnt_r + 16'h0001);
            blink_r <= blink_r ^ blink_end;
         end
         led_g_r <= led_ctrl_r[`DIO_LED_GREEN_BIT] & ~trip & blink_r; // [RL17]
         led_r_r <= led_ctrl_r[`DIO_LED_RED_BIT] & trip & blink_r; // [RL17]
      end
   end

   // ----
   // Read path
   // ----
   wire logic [31:0] rd_reg =
      (paddr == `DIO_OFS_IN_SFE) ? {16'h0000, in_sfe_r} :
      (paddr == `DIO_OFS_IN_INV) ? {16'h0000, in_inv_r} :
      (paddr == `DIO_OFS_IN_FEN) ? {16'h0000, in_fen_r} :
      (paddr == `DIO_OFS_IN_FVAL) ? {16'h0000, in_fval_r} :
      (paddr == `DIO_OFS_IN_RAW) ? {16'h0000, phys_f} :
      (paddr == `DIO_OFS_IN_RTEN) ? {31'h0, in_rten_r} :
      (paddr == `DIO_OFS_IN_STAT) ? din_stat_r :
      (paddr == `DIO_OFS_OUT_CMD) ? out_cmd_r :
      (paddr == `DIO_OFS_OUT_POL) ? out_pol_r :
      (paddr == `DIO_OFS_OUT_MEN) ? out_men_r :
      (paddr == `DIO_OFS_OUT_MVAL) ? out_mval_r :
      (paddr == `DIO_OFS_OUT_APPL) ? out_appl_r :
      (paddr == `DIO_OFS_OUT_RTEN) ? {31'h0, out_rten_r} :
      (paddr == `DIO_OFS_LED) ? {30'h0, led_ctrl_r} :
      (paddr == `DIO_OFS_FLT_REACT) ? {16'h0000, flt_react_r} :
      (paddr == `DIO_OFS_FLT_STAT) ? {30'h0, permit_r, trip} :
      (paddr == `DIO_OFS_PIN_DIR) ? {28'h0, pin_dir_r} : 32'h0000_0000;
   wire logic [31:0] rd_data = is_route ? {24'h000000, route_r[route_idx]} : rd_reg;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= acc;
         pslverr_r <= acc & ~hit;
         prdata_r <= (acc && !pwrite && hit) ? rd_data : 32'h0000_0000;
      end
   end

   // ----
   // Outputs
   // ----
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign dio_o = dio_o_r;
   assign dio_oe = dio_oe_r;
   assign brake_o = 1'b0;
   assign brake_oe = brake_oe_r;
   assign led_green = led_g_r;
   assign led_red = led_r_r;
   assign motion_permit = permit_r;
   assign fault_active = trip;
   assign fault_reaction = flt_react_r;

endmodule : dio_top

`default_nettype wire

// >>> verif/dio_top_properties.sv
// Checker of the digital I/O block: APB timing and output conditioning.
// Assumes the ports of dio_top; bound into every instance of it.
`timescale 1ns/1ps
`default_nettype none
`include "dio_defines.svh"

module dio_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic [3:0] dio_o,
   input wire logic brake_o,
   input wire logic brake_oe,
   input wire logic led_green,
   input wire logic led_red,
   input wire logic motion_permit,
   input wire logic fault_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ----
   // Shadow of the output registers
   // ----
   logic [31:0] cmd_r, pol_r, men_r, mval_r;
   logic [1:0] led_r;
   logic [3:0] pin_r;
   logic brk_r;
   wire wr_hit = psel && penable && pready && pwrite;
   wire [31:0] appl = ((men_r & mval_r) | (~men_r & (cmd_r ^ pol_r))) & 32'h000F_0001;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {cmd_r, pol_r, men_r, mval_r, led_r} <= '0;
      end else if (wr_hit) begin
         case (paddr)
            `DIO_OFS_OUT_CMD: cmd_r <= pwdata;
            `DIO_OFS_OUT_POL: pol_r <= pwdata;
            `DIO_OFS_OUT_MEN: men_r <= pwdata;
            `DIO_OFS_OUT_MVAL: mval_r <= pwdata;
            `DIO_OFS_LED: led_r <= pwdata[1:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {pin_r, brk_r} <= '0;
      end else begin
         {pin_r, brk_r} <= {appl[19:16], ~appl[0]};
      end
   end
   // ----
   // Properties
   // ----
   property p_pin_level; dio_o == pin_r; endproperty
   a_pin_level: assert property (p_pin_level) else $error("pin level");
   property p_brake_drive; brake_oe == brk_r; endproperty
   a_brake_drive: assert property (p_brake_drive) else $error("brake drive");
   property p_brake_od; brake_o == 1'b0; endproperty
   a_brake_od: assert property (p_brake_od) else $error("brake high");
   property p_fault_halt; fault_active |-> !motion_permit; endproperty
   a_fault_halt: assert property (p_fault_halt) else $error("motion in fault");
   property p_leds_off; (led_r == 2'b00) [*3] |-> !led_green && !led_red; endproperty
   a_leds_off: assert property (p_leds_off) else $error("led lit");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
   property p_wait_state; $rose(penable) && psel |-> !pready ##1 pready; endproperty
   a_wait_state: assert property (p_wait_state) else $error("ready timing");
   property p_refused; pslverr |-> pready && prdata == 32'h0; endproperty
   a_refused: assert property (p_refused) else $error("error data");
   property p_unmapped; pready && paddr >= 8'h44 && paddr < 8'h80 |-> pslverr; endproperty
   a_unmapped: assert property (p_unmapped) else $error("no error");
   c_refused: cover property (pready && pslverr);
   c_fault: cover property ($rose(fault_active));
   c_brake: cover property ($fell(brake_oe));
endmodule : dio_chk

bind dio_top dio_chk u_chk (.clk(clk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .dio_o(dio_o), .brake_o(brake_o),
   .brake_oe(brake_oe), .led_green(led_green), .led_red(led_red),
   .motion_permit(motion_permit), .fault_active(fault_active));
`default_nettype wire

// >>> verif/dio_field.sv
// Field side: switches and sensors on the input pins.
// Assumes dio_o/dio_oe of the block; a driven shared pin reads back its own level.
`timescale 1ns/1ps
`default_nettype none

module dio_field (
   // Wanted levels
   input wire logic [5:0] sw,
   input wire logic [2:0] hall,
   input wire logic [2:0] enc,
   // Block outputs
   input wire logic [3:0] dio_o,
   input wire logic [3:0] dio_oe,
   // Block inputs
   output logic [5:0] dio_in,
   output logic [2:0] hall_in,
   output logic [2:0] enc_in
);
   assign dio_in = {sw[5:4], (dio_oe & dio_o) | (~dio_oe & sw[3:0])};
   assign hall_in = hall;
   assign enc_in = enc;
endmodule : dio_field
`default_nettype wire

// >>> verif/dio_top_tb.sv
// Self-checking bench of the digital I/O block over APB.
// Assumes dio_top, dio_field and the bound checker; sample period cut to SC cycles.
`timescale 1ns/1ps
`default_nettype none
`include "dio_defines.svh"

module dio_top_tb;
   localparam int SC = 10;
   localparam int LAT = 3 * SC + 8;
   localparam logic [7:0] CODES [26] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
      8'h07, 8'h10, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h80, 8'h81, 8'h86, 8'h90,
      8'hC1, 8'hC3, 8'hC6, 8'h47, 8'hC7, 8'h20, 8'hFF};
   typedef struct {string what; logic [31:0] m; logic [32:0] e;} dio_note_type;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rnd, cmd, pol, men, mval, stat;
   logic [5:0] sw, dio_in;
   logic [2:0] hall, enc, hall_in, enc_in;
   logic [3:0] dio_o, dio_oe;
   logic brake_o, brake_oe, led_green, led_red, motion_permit, fault_active;
   logic [15:0] fault_reaction;
   dio_note_type notes[$];
   dio_note_type nt;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;

   dio_top #(.SAMPLE_CYCLES(SC)) u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dio_in(dio_in), .hall_in(hall_in),
      .enc_in(enc_in), .dio_o(dio_o), .dio_oe(dio_oe), .brake_o(brake_o),
      .brake_oe(brake_oe), .led_green(led_green), .led_red(led_red),
      .motion_permit(motion_permit), .fault_active(fault_active),
      .fault_reaction(fault_reaction));
   dio_field u_field (.sw(sw), .hall(hall), .enc(enc), .dio_o(dio_o), .dio_oe(dio_oe),
      .dio_in(dio_in), .hall_in(hall_in), .enc_in(enc_in));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0);
   endfunction : lfsr

   // Expected level of one routing code
   function automatic logic src(input logic [7:0] c);
      logic [6:0] s;
      logic v;
      s = c[6:0];
      v = 1'b0;
      if (s >= 7'h01 && s <= 7'h06) v = sw[s[2:0] - 3'd1];
      if (s >= 7'h41 && s <= 7'h43) v = hall[s[2:0] - 3'd1];
      if (s >= 7'h44 && s <= 7'h46) v = enc[s[2:0] - 3'd4];
      if (s > 7'h10 && (s < 7'h41 || s > 7'h46)) return 1'b0;
      return v ^ c[7];
   endfunction : src

   task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input string w, input logic [7:0] a, input logic [31:0] m,
                     input logic [32:0] e);
      notes.push_back('{w, m, e});
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   always @(posedge clk) begin
      if ((psel & penable & pready & ~pwrite) === 1'b1) begin
         nt = notes.pop_front();
         check(nt.what, {pslverr, prdata & nt.m}, nt.e & {1'b1, nt.m});
      end
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, sw, hall, enc} = '0;
      sys_rst = 1'b1;
      rnd = 32'hF9E8_2C4D;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd("fault state", `DIO_OFS_FLT_STAT, 32'h3, 33'h2);
      rd("unmapped", 8'h60, 32'hFFFF_FFFF, 33'h1_0000_0000);
      apb(1'b1, 8'h7C, 32'hFFFF_FFFF);
      $display("reset test done");
      sw <= 6'h1A;
      pol = 32'h05;
      apb(1'b1, `DIO_OFS_IN_INV, pol);
      apb(1'b1, `DIO_OFS_IN_SFE, 32'h25);
      repeat (LAT) @(posedge clk);
      stat = {10'h0, sw ^ pol[5:0], 10'h0, (sw ^ pol[5:0]) & 6'h25};
      rd("normal status", `DIO_OFS_IN_STAT, '1, {1'b0, stat});
      sw <= 6'h3A;
      repeat (SC / 2) @(posedge clk);
      sw <= 6'h1A;
      repeat (LAT) @(posedge clk);
      rd("short pulse", `DIO_OFS_IN_STAT, '1, {1'b0, stat});
      apb(1'b1, `DIO_OFS_IN_RTEN, 32'h1);
      apb(1'b1, `DIO_OFS_IN_INV, 32'h3F);
      apb(1'b1, `DIO_OFS_IN_FEN, 32'h3F);
      repeat (LAT) @(posedge clk);
      rd("routed status", `DIO_OFS_IN_STAT, '1, {1'b0, stat});
      rd("entry 1", 8'h80, 32'hFF, 33'h81);
      rd("entry 2", 8'h84, 32'hFF, 33'h00);
      rd("entry 18", 8'hC4, 32'hFF, 33'h02);
      $display("mode test done");
      for (int i = 0; i < 26; i++) begin
         rnd = lfsr(rnd);
         sw <= rnd[5:0];
         hall <= rnd[8:6];
         enc <= rnd[11:9];
         apb(1'b1, 8'h80 + 8'(i * 4), {24'h0, CODES[i]});
         repeat (LAT) @(posedge clk);
         rd("routed bit", `DIO_OFS_IN_STAT, 32'h1 << i, {1'b0, 32'(src(CODES[i])) << i});
      end
      $display("routing test done");
      sw <= 6'h08;
      apb(1'b1, 8'h8C, 32'h04);
      repeat (LAT) @(posedge clk);
      apb(1'b1, `DIO_OFS_IN_SFE, 32'h08);
      rd("permit", `DIO_OFS_FLT_STAT, 32'h3, 33'h2);
      sw <= 6'h00;
      repeat (LAT) @(posedge clk);
      rd("trip", `DIO_OFS_FLT_STAT, 32'h3, 33'h1);
      check("motion", {31'h0, motion_permit, fault_active}, 33'h1);
      apb(1'b1, `DIO_OFS_FLT_STAT, 32'h1);
      rd("held trip", `DIO_OFS_FLT_STAT, 32'h3, 33'h1);
      sw <= 6'h08;
      repeat (LAT) @(posedge clk);
      apb(1'b1, `DIO_OFS_FLT_STAT, 32'h1);
      rd("cleared", `DIO_OFS_FLT_STAT, 32'h3, 33'h2);
      apb(1'b1, `DIO_OFS_IN_SFE, 32'h0);
      sw <= 6'h00;
      repeat (LAT) @(posedge clk);
      rd("gated", `DIO_OFS_FLT_STAT, 32'h3, 33'h2);
      apb(1'b1, `DIO_OFS_FLT_REACT, 32'hABCD_2345);
      rd("reaction", `DIO_OFS_FLT_REACT, '1, 33'h2345);
      check("reaction pins", {17'h0, fault_reaction}, 33'h2345);
      $display("interlock test done");
      apb(1'b1, `DIO_OFS_PIN_DIR, 32'hFF);
      rd("direction", `DIO_OFS_PIN_DIR, '1, 33'hF);
      for (int i = 0; i < 6; i++) begin
         cmd = lfsr(rnd);
         pol = lfsr(cmd);
         men = lfsr(pol);
         mval = lfsr(men);
         rnd = mval;
         apb(1'b1, `DIO_OFS_OUT_CMD, cmd);
         apb(1'b1, `DIO_OFS_OUT_POL, pol);
         apb(1'b1, `DIO_OFS_OUT_MEN, men);
         apb(1'b1, `DIO_OFS_OUT_MVAL, mval);
         stat = ((men & mval) | (~men & (cmd ^ pol))) & 32'h000F_0001;
         rd("applied", `DIO_OFS_OUT_APPL, '1, {1'b0, stat});
         check("pins", {24'h0, dio_o, dio_oe, brake_oe}, {24'h0, stat[19:16], 4'hF, ~stat[0]});
      end
      apb(1'b1, `DIO_OFS_OUT_RTEN, 32'h1);
      rd("output routing", `DIO_OFS_OUT_RTEN, '1, 33'h1);
      apb(1'b1, `DIO_OFS_LED, 32'h3);
      rd("leds", `DIO_OFS_LED, '1, 33'h3);
      $display("output test done");
      conclude();
   end
endmodule : dio_top_tb
`default_nettype wire
